// >>> verilog/xosc_pkg.sv
package xosc_pkg;

   // Register map
   localparam logic [7:0]  XOSC_CTRL_ADDR = 8'h00;
   localparam logic [7:0]  XOSC_STAT_ADDR = 8'h04;
   localparam logic [7:0]  XOSC_CTRL_RST  = 8'h00;
   localparam logic [7:0]  XOSC_CTRL_WMASK = 8'haf;

   // Field positions in the control register
   localparam int XOSC_BIT_REF_EN  = 7;
   localparam int XOSC_BIT_STOP_EN = 5;
   localparam int XOSC_BIT_CAP2    = 3;
   localparam int XOSC_BIT_CAP4    = 2;
   localparam int XOSC_BIT_CAP8    = 1;
   localparam int XOSC_BIT_CAP16   = 0;

   // Start-up count in raw crystal cycles
   localparam logic [12:0] XOSC_STARTUP_CYCLES = 13'h1000;

   // AXI responses
   localparam logic [1:0]  XOSC_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  XOSC_RESP_SLVERR = 2'h2;

   // Oscillator states
   typedef enum logic [1:0] {
      XOSC_OFF     = 2'b00,
      XOSC_STARTUP = 2'b01,
      XOSC_STABLE  = 2'b10,
      XOSC_EXTCLK  = 2'b11
   } xosc_state_t;

   // Clock and analog control outputs toward consumers
   typedef struct packed {
      logic       osc_clk_out;
      logic       peripheral_ref_clock;
      logic [3:0] load_cap;
      logic       crystal_output_oe;
   } xosc_out_t;

   // Whole module state
   typedef struct packed {
      logic [7:0]  ctrl;
      xosc_state_t state;
      logic [12:0] count;
      logic        startup_count_done;
      logic        raw_d1;
      logic        raw_d2;
      logic        awvalid_seen;
      logic [7:0]  awaddr;
      logic        wvalid_seen;
      logic [7:0]  wdata;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        awready;
      logic        wready;
      logic        arready;
      xosc_out_t   out;
   } xosc_regs_t;

   // Decode of a valid register offset
   function automatic logic xosc_addr_ok(input logic [7:0] addr);
      return (addr == XOSC_CTRL_ADDR) || (addr == XOSC_STAT_ADDR);
   endfunction

endpackage

// >>> verilog/xosc_ctrl.sv
// Notes on behaviour
// - Control bit 7 enables the peripheral reference clock; zero keeps it inactive.
// - Bit 5 keeps the reference clock running in Stop when enable preceded Stop.
// - Bits 6 and 4 read as zero and ignore writes.
// - Bits 3..0 select 2, 4, 8, 16 pF load capacitors; zero deselects.
// - Off state holds raw clock static and decouples pins, unless external mode; osc_clk_out is held static when off in external mode too.
// - Start-up begins on generate enable with internal select; output gated for 4096 cycles.
// - Enable, internal select and count done enter stable; raw clock passes through.
// - Enable without internal select buffers the input pin clock onto output.
// - In external clock mode the crystal output pin is free for general I/O.
// - Counter and done flag clear whenever generate enable is off.
// - Control register kept through low-leakage stop; very-low-leakage wake resets it.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module xosc_ctrl
   import xosc_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address and data
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Oscillator control inputs
   input  wire logic        osc_gen_enable,
   input  wire logic        internal_osc_select,
   input  wire logic        stop_mode,
   input  wire logic        vlls_wakeup,
   // Raw clock sources, sampled as levels
   input  wire logic        raw_crystal_clock,
   input  wire logic        crystal_input_pin,
   // Clock and analog controls out
   output logic             osc_clk_out,
   output logic             peripheral_ref_clock,
   output logic [3:0]       load_cap,
   output logic             crystal_output_oe,
   output logic             startup_count_done
);

   xosc_regs_t r;
   xosc_regs_t next_r;
   logic       raw_rise;
   logic       ref_src;
   logic       do_write;
   logic [7:0] wr_val;

   // Next-state logic
   always_comb
   begin
      next_r   = r;
      raw_rise = r.raw_d1 & ~r.raw_d2;
      do_write = 1'b0;
      wr_val   = r.ctrl;

      // Raw crystal clock edge detection, static when off
      next_r.raw_d1 = raw_crystal_clock & osc_gen_enable & internal_osc_select;
      next_r.raw_d2 = r.raw_d1;

      // Oscillator state sequence
      if (!osc_gen_enable)
      begin
         next_r.state              = XOSC_OFF;
         next_r.count              = 13'h0000;
         next_r.startup_count_done = 1'b0;
      end
      else if (!internal_osc_select)
      begin
         // Done flag kept while generation stays on
         next_r.state              = XOSC_EXTCLK;
      end
      else
      begin
         case (r.state)
            XOSC_STARTUP:
            begin
               if (raw_rise)
               begin
                  next_r.count = r.count + 13'h0001;
                  if (r.count + 13'h0001 == XOSC_STARTUP_CYCLES)
                  begin
                     next_r.startup_count_done = 1'b1;
                     next_r.state              = XOSC_STABLE;
                  end
               end
            end
            XOSC_STABLE:
            begin
               next_r.startup_count_done = 1'b1;
            end
            default:
            begin
               // No recount when returning from external mode
               if (r.startup_count_done)
                  next_r.state = XOSC_STABLE;
               else
               begin
                  next_r.state              = XOSC_STARTUP;
                  next_r.count              = 13'h0000;
                  next_r.startup_count_done = 1'b0;
               end
            end
         endcase
      end

      // Output clock selection
      case (next_r.state)
         XOSC_STABLE: ref_src = r.raw_d1;
         XOSC_EXTCLK: ref_src = crystal_input_pin;
         default:     ref_src = 1'b0;
      endcase
      next_r.out.osc_clk_out = ref_src;
      // Peripheral reference gated by enable and stop settings
      next_r.out.peripheral_ref_clock = ref_src & r.ctrl[XOSC_BIT_REF_EN]
                                        & (~stop_mode | r.ctrl[XOSC_BIT_STOP_EN]);
      next_r.out.load_cap = {r.ctrl[XOSC_BIT_CAP2], r.ctrl[XOSC_BIT_CAP4],
                             r.ctrl[XOSC_BIT_CAP8], r.ctrl[XOSC_BIT_CAP16]};
      // Output pin driven only by the amplifier in crystal states
      next_r.out.crystal_output_oe = (next_r.state == XOSC_STARTUP)
                                     || (next_r.state == XOSC_STABLE);

      // Write address and data capture, either order
      if (r.awready && s_axi_awvalid)
      begin
         next_r.awvalid_seen = 1'b1;
         next_r.awaddr       = s_axi_awaddr;
         next_r.awready      = 1'b0;
      end
      if (r.wready && s_axi_wvalid)
      begin
         next_r.wvalid_seen = 1'b1;
         next_r.wdata       = s_axi_wstrb[0] ? s_axi_wdata[7:0] : r.ctrl;
         next_r.wready      = 1'b0;
      end
      if (r.awvalid_seen && r.wvalid_seen && !r.bvalid)
      begin
         next_r.bvalid       = 1'b1;
         next_r.awvalid_seen = 1'b0;
         next_r.wvalid_seen  = 1'b0;
         if (r.awaddr == XOSC_CTRL_ADDR)
         begin
            do_write     = 1'b1;
            wr_val       = r.wdata & XOSC_CTRL_WMASK;
            next_r.bresp = XOSC_RESP_OKAY;
         end
         else if (xosc_addr_ok(r.awaddr))
            next_r.bresp = XOSC_RESP_OKAY;
         else
            next_r.bresp = XOSC_RESP_SLVERR;
      end
      if (r.bvalid && s_axi_bready)
      begin
         next_r.bvalid  = 1'b0;
         next_r.awready = 1'b1;
         next_r.wready  = 1'b1;
      end

      // Read channel
      if (r.arready && s_axi_arvalid)
      begin
         next_r.arready = 1'b0;
         next_r.rvalid  = 1'b1;
         if (s_axi_araddr == XOSC_CTRL_ADDR)
         begin
            next_r.rdata = {24'h000000, r.ctrl & XOSC_CTRL_WMASK};
            next_r.rresp = XOSC_RESP_OKAY;
         end
         else if (s_axi_araddr == XOSC_STAT_ADDR)
         begin
            next_r.rdata = {29'h00000000, r.startup_count_done, r.state};
            next_r.rresp = XOSC_RESP_OKAY;
         end
         else
         begin
            next_r.rdata = 32'h00000000;
            next_r.rresp = XOSC_RESP_SLVERR;
         end
      end
      if (r.rvalid && s_axi_rready)
      begin
         next_r.rvalid  = 1'b0;
         next_r.arready = 1'b1;
      end

      // Control register update; wake from deepest stop restores reset value
      if (vlls_wakeup)
         next_r.ctrl = XOSC_CTRL_RST;
      else if (do_write)
         next_r.ctrl = wr_val;
   end

   // State register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r         <= '0;
         r.ctrl    <= XOSC_CTRL_RST;
         r.state   <= XOSC_OFF;
         r.awready <= 1'b1;
         r.wready  <= 1'b1;
         r.arready <= 1'b1;
      end
      else
         r <= next_r;
   end

   // Outputs straight from flip-flops
   assign s_axi_awready        = r.awready;
   assign s_axi_wready         = r.wready;
   assign s_axi_bvalid         = r.bvalid;
   assign s_axi_bresp          = r.bresp;
   assign s_axi_arready        = r.arready;
   assign s_axi_rvalid         = r.rvalid;
   assign s_axi_rdata          = r.rdata;
   assign s_axi_rresp          = r.rresp;
   assign osc_clk_out          = r.out.osc_clk_out;
   assign peripheral_ref_clock = r.out.peripheral_ref_clock;
   assign load_cap             = r.out.load_cap;
   assign crystal_output_oe    = r.out.crystal_output_oe;
   assign startup_count_done   = r.startup_count_done;

endmodule

// >>> sim/xosc_checker.sv
`timescale 1ns/1ps
module xosc_checker
   import xosc_pkg::*;
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   // Oscillator
   input wire logic        osc_gen_enable,
   input wire logic        internal_osc_select,
   input wire logic        raw_crystal_clock,
   input wire logic        crystal_input_pin,
   input wire logic        osc_clk_out,
   input wire logic        crystal_output_oe,
   input wire logic        startup_count_done
);
   logic [13:0] edge_cnt;
   logic        raw_q;

   // Raw clock rising edges seen since generation was enabled
   always_ff @(posedge aclk)
   begin
      raw_q <= raw_crystal_clock;
      if (!aresetn || !osc_gen_enable)
         edge_cnt <= 14'h0;
      else if (raw_crystal_clock && !raw_q && edge_cnt != 14'h3fff)
         edge_cnt <= edge_cnt + 14'h1;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_reserved_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[6] && !s_axi_rdata[4])
      else $error("reserved bit read as one");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_done_clear: assert property (!osc_gen_enable |=> !startup_count_done)
      else $error("done flag not cleared");
   a_done_sticky: assert property (startup_count_done && osc_gen_enable |=> startup_count_done)
      else $error("done flag lost");
   a_count_exact: assert property ($rose(startup_count_done) |-> edge_cnt >= 14'h1000 && edge_cnt <= 14'h1001)
      else $error("start-up count wrong");
   a_gated_startup: assert property ((osc_gen_enable && internal_osc_select && !startup_count_done)[*3]
      |-> !osc_clk_out)
      else $error("clock leaks during start-up");
   a_ext_follow: assert property ((osc_gen_enable && !internal_osc_select)[*3]
      |-> osc_clk_out == $past(crystal_input_pin))
      else $error("external clock not passed");
   a_pin_free: assert property ((osc_gen_enable && !internal_osc_select)[*3] |-> !crystal_output_oe)
      else $error("output pin driven in external mode");
   a_off_quiet: assert property ((!osc_gen_enable)[*3] |-> !osc_clk_out && !crystal_output_oe)
      else $error("clock active while off");
endmodule

bind xosc_ctrl xosc_checker xosc_checker_i (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .osc_gen_enable, .internal_osc_select,
   .raw_crystal_clock, .crystal_input_pin, .osc_clk_out, .crystal_output_oe, .startup_count_done);

// >>> sim/test_crystal_osc_control.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_crystal_osc_control
   import xosc_pkg::*;
;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   logic [7:0]  ones;
   int          n;
   logic [31:0] seed = 32'h63;
   logic [33:0] read_q[$];
   logic [1:0]  resp_q[$];
   logic [33:0] rexp;
   logic [1:0]  bexp;
   logic [7:0]  gate_ctrl [5] = '{8'h00, 8'h80, 8'h80, 8'ha0, 8'h20};
   logic        gate_stop [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   logic        gate_on   [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   logic        aclk = 1'b0, aresetn = 1'b0, raw_run = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        osc_gen_enable = 1'b0, internal_osc_select = 1'b0, stop_mode = 1'b0, vlls_wakeup = 1'b0;
   logic        raw_crystal_clock = 1'b0, crystal_input_pin = 1'b0;
   logic [1:0]  div = 2'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        osc_clk_out, peripheral_ref_clock, crystal_output_oe, startup_count_done;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [3:0]  load_cap;

   xosc_ctrl xosc_ctrl_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .osc_gen_enable,
      .internal_osc_select, .stop_mode, .vlls_wakeup, .raw_crystal_clock, .crystal_input_pin, .osc_clk_out,
      .peripheral_ref_clock, .load_cap, .crystal_output_oe, .startup_count_done);

   // 200 MHz clock
   always #2.5 aclk = ~aclk;

   // Pin clock every cycle, raw crystal clock at one eighth
   always @(posedge aclk)
   begin
      crystal_input_pin <= ~crystal_input_pin;
      div <= div + 2'h1;
      if (div == 2'h3)
         raw_crystal_clock <= raw_run & ~raw_crystal_clock;
   end

   // Response watcher, oldest note first
   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready)
      begin
         rexp = read_q.pop_front();
         `CHK({s_axi_rresp, s_axi_rdata}, rexp)
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
         bexp = resp_q.pop_front();
         `CHK(s_axi_bresp, bexp)
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Write with both channels offered together
   task automatic wr(input logic [7:0] d, input logic [3:0] s);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      resp_q.push_back(XOSC_RESP_OKAY);
      @(posedge aclk);
      s_axi_awaddr <= XOSC_CTRL_ADDR;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         aw_done |= s_axi_awvalid & s_axi_awready;
         w_done |= s_axi_wvalid & s_axi_wready;
         s_axi_awvalid <= ~aw_done;
         s_axi_wvalid <= ~w_done;
      end while (!(aw_done && w_done));
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      read_q.push_back(e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask

   // Run is about 34000 cycles
   initial
   begin
      #250000;
      n_mismatch++;
      print_verdict;
   end

   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(XOSC_CTRL_ADDR, {XOSC_RESP_OKAY, 32'h0});
      rd(8'h08, {XOSC_RESP_SLVERR, 32'h0});
      // Random control values
      repeat (6)
      begin
         seed = xs(seed);
         wr(seed[7:0], 4'hf);
         rd(XOSC_CTRL_ADDR, {XOSC_RESP_OKAY, 24'h0, seed[7:0] & 8'haf});
         `CHK(load_cap, seed[3:0])
      end
      // Lane 0 disabled, then wake from deep stop
      wr(8'h0f, 4'he);
      rd(XOSC_CTRL_ADDR, {XOSC_RESP_OKAY, 24'h0, seed[7:0] & 8'haf});
      vlls_wakeup <= 1'b1;
      @(posedge aclk) vlls_wakeup <= 1'b0;
      rd(XOSC_CTRL_ADDR, {XOSC_RESP_OKAY, 32'h0});
      // Reference clock gating in external clock mode
      osc_gen_enable <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         wr(gate_ctrl[i], 4'h1);
         stop_mode <= gate_stop[i];
         repeat (3) @(posedge aclk);
         ones = 0;
         repeat (20) @(posedge aclk) ones += peripheral_ref_clock;
         `CHK(ones != 0, gate_on[i])
      end
      `CHK(crystal_output_oe, 1'b0)
      // Crystal start-up count
      osc_gen_enable <= 1'b0;
      repeat (3) @(posedge aclk);
      internal_osc_select <= 1'b1;
      raw_run <= 1'b1;
      osc_gen_enable <= 1'b1;
      repeat (4090 * 8) @(posedge aclk);
      `CHK(startup_count_done, 1'b0)
      `CHK({osc_clk_out, crystal_output_oe}, 2'b01)
      for (n = 0; n < 400 && startup_count_done !== 1'b1; n++) @(posedge aclk);
      `CHK(startup_count_done, 1'b1)
      repeat (50) @(posedge aclk);
      `CHK(startup_count_done, 1'b1)
      `CHK(crystal_output_oe, 1'b1)
      ones = 0;
      repeat (20) @(posedge aclk) ones += osc_clk_out;
      `CHK(ones != 0, 1'b1)
      osc_gen_enable <= 1'b0;
      repeat (2) @(posedge aclk);
      `CHK(startup_count_done, 1'b0)
      `CHK({osc_clk_out, crystal_output_oe}, 2'b00)
      osc_gen_enable <= 1'b1;
      repeat (800) @(posedge aclk);
      `CHK(startup_count_done, 1'b0)
      print_verdict;
   end
endmodule
